// ### rtl/qpsc_defs.vh
`ifndef QPSC_DEFS_VH
`define QPSC_DEFS_VH

// ****************************************************************
// timing
// ****************************************************************
// clock rate in kHz (40 ns period)
`define QPSC_CLK_KHZ 25000
// longest nonvolatile write time in ms
`define QPSC_NV_WRITE_MS 10
// longest time in whole cycles (10 ms at 25 MHz), sized to the counter
`define QPSC_NV_WRITE_CYCLES 18'h3D090
// width of the nonvolatile write counter
`define QPSC_NV_CNT_W 18

// ****************************************************************
// instruction byte fields
// ****************************************************************
`define QPSC_OPC_MSB 7
`define QPSC_OPC_LSB 4
`define QPSC_REG_SEL_HI 3
`define QPSC_REG_SEL_LO 2
`define QPSC_POT_MSB 1
`define QPSC_POT_LSB 0

// ****************************************************************
// identification byte fields
// ****************************************************************
`define QPSC_ID_TYPE_MSB 7
`define QPSC_ID_TYPE_LSB 4
`define QPSC_ID_ADDR_MSB 1
`define QPSC_ID_ADDR_LSB 0

// ****************************************************************
// operation codes
// ****************************************************************
`define QPSC_OPC_RD_WIPER 4'h9
`define QPSC_OPC_WR_WIPER 4'hA
`define QPSC_OPC_RD_PRESET 4'hB
`define QPSC_OPC_WR_PRESET 4'hC
`define QPSC_OPC_PRESET_TO_WIPER 4'hD
`define QPSC_OPC_WIPER_TO_PRESET 4'hE
`define QPSC_OPC_ALL_PRESET_TO_WIPER 4'h1
`define QPSC_OPC_ALL_WIPER_TO_PRESET 4'h8

// ****************************************************************
// reset and power-on values
// ****************************************************************
`define QPSC_WIPER_RST 8'h00
`define QPSC_TAP_RST 256'h1
`define QPSC_PRESET_INIT 8'h80
`define QPSC_TAP_MAX 8'hFF
`define QPSC_TAP_MIN 8'h00

`endif

// ### rtl/qpsc_nv_timer.v
`timescale 1ns/100ps
`default_nettype none
`include "qpsc_defs.vh"

// ****************************************************************
// nonvolatile write timer: busy for a fixed count after start
// ****************************************************************
module qpsc_nv_timer #(
  parameter [`QPSC_NV_CNT_W-1:0] CYCLES = `QPSC_NV_WRITE_CYCLES
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // control
  input wire start_i,
  // status
  output reg busy_o,
  output reg done_o
);

  reg [`QPSC_NV_CNT_W-1:0] count; // cycles left in the write

  // count down; done fires in the first cycle after busy falls
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      count <= {`QPSC_NV_CNT_W{1'b0}};
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        // a start while busy is dropped by the caller anyway
        busy_o <= 1'b1;
        count <= CYCLES - 1'b1;
      end else if (busy_o) begin
        if (count == {`QPSC_NV_CNT_W{1'b0}}) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end

endmodule // qpsc_nv_timer

`default_nettype wire

// ### rtl/qpsc_serial_ctrl.v
// Summary of operation
// - write protect low blocks preset writes
// - serial input sampled on serial clock rise
// - serial output floats unless driving read data
// - each array exactly one tap enabled
// - wiper value decoded one-hot onto taps
// - four wiper registers, one per pot
// - wiper: serial write, transfer, or step
// - power-up loads wiper from preset zero
// - wiper registers are volatile
// - four presets per pot, read, write, exchange
// - preset write completes within 10 ms
// - commit starts on select rise after write
// - pending flag returned by read status
// - first byte is identification, type checked
// - strap address bits must match
// - opcode high nibble, next two select preset
// - deselected means serial output floats
// - read data shifted out on clock fall
// - pause input freezes sequence, clock low
// - nothing accepted before select falls
`timescale 1ns/100ps
`default_nettype none
`include "qpsc_defs.vh"

module qpsc_serial_ctrl #(
  // device type code; value is arbitrary
  parameter [3:0] DEV_TYPE = 4'hA,
  // read status and step opcodes
  parameter [3:0] OPC_RD_STATUS = 4'h5,
  parameter [3:0] OPC_STEP = 4'h2,
  // nonvolatile write length in cycles
  parameter [`QPSC_NV_CNT_W-1:0] NV_WRITE_CYCLES = `QPSC_NV_WRITE_CYCLES
) (
  // clock and reset
  input wire CLK_I,
  input wire SYS_RST_I,
  // serial link pins
  input wire SPI_SCK_I,
  input wire SPI_CS_N_I,
  input wire SPI_SI_I,
  input wire SPI_HOLD_N_I,
  output reg SPI_SO_O,
  output reg SPI_SO_OE_O,
  // protection and strap pins
  input wire WP_N_I,
  input wire [1:0] STRAP_ADDR_I,
  // status
  output reg NV_WRITE_PENDING_O,
  // tap selects, one-hot per pot
  output reg [255:0] WIPER_TAP0_O,
  output reg [255:0] WIPER_TAP1_O,
  output reg [255:0] WIPER_TAP2_O,
  output reg [255:0] WIPER_TAP3_O
);

  // ****************************************************************
  // states, one-hot
  // ****************************************************************
  localparam [5:0] ST_IDLE = 6'h01; // deselected or rest of frame ignored
  localparam [5:0] ST_ID = 6'h02; // shifting identification byte
  localparam [5:0] ST_INSTR = 6'h04; // shifting instruction byte
  localparam [5:0] ST_DATA = 6'h08; // shifting write data byte
  localparam [5:0] ST_READ = 6'h10; // driving read data
  localparam [5:0] ST_STEP = 6'h20; // single-step wiper movement

  // ****************************************************************
  // functions
  // ****************************************************************
  // one-hot tap select for a wiper value
  function [255:0] tap_onehot;
    input [7:0] pos;
    begin
      tap_onehot = 256'h0;
      tap_onehot[pos] = 1'b1;
    end
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // bit order: sck, cs_n, si, hold_n, wp_n, strap[1:0]
  reg [6:0] pin_meta; // first stage, read only by second
  reg [6:0] pin_sync; // second stage, safe to use
  reg sck_last; // previous synchronised clock
  reg cs_n_last; // previous synchronised select

  wire sck_s = pin_sync[6];
  wire cs_n_s = pin_sync[5];
  wire si_s = pin_sync[4];
  wire hold_n_s = pin_sync[3];
  wire wp_n_s = pin_sync[2];
  wire [1:0] strap_addr = pin_sync[1:0];

  // two flops on every pin; the clock pin is sampled, not used as clock
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pin_meta <= 7'h3C;
      pin_sync <= 7'h3C;
      sck_last <= 1'b0; // clock idles low, no false edge after reset
      cs_n_last <= 1'b1;
    end else begin
      pin_meta <= {SPI_SCK_I, SPI_CS_N_I, SPI_SI_I, SPI_HOLD_N_I,
                   WP_N_I, STRAP_ADDR_I};
      pin_sync <= pin_meta;
      sck_last <= sck_s;
      cs_n_last <= cs_n_s;
    end
  end

  // ****************************************************************
  // edges and pause
  // ****************************************************************
  reg paused; // serial transfer frozen by pause input
  wire cs_fall = cs_n_last && !cs_n_s;
  wire cs_rise = !cs_n_last && cs_n_s;
  wire sck_rise = !sck_last && sck_s && !paused;
  wire sck_fall = sck_last && !sck_s && !paused;

  // pause enters only while the serial clock is low, and leaves then or on deselect
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      paused <= 1'b0;
    end else if (cs_n_s) begin
      paused <= 1'b0;
    end else if (!sck_s) begin
      paused <= !hold_n_s;
    end
  end

  // ****************************************************************
  // storage
  // ****************************************************************
  reg [7:0] wiper_position [0:3]; // volatile, one per pot
  reg [7:0] pot_preset_store [0:15]; // index {pot, preset}
  reg [7:0] stage_val [0:3]; // values waiting to be committed
  reg stage_valid; // complete write received this frame
  reg stage_all; // global transfer to all pots
  reg [1:0] stage_pot; // pot of a single write
  reg [1:0] stage_reg; // preset selected for the write
  reg init_pend; // power-up recall still to do
  integer i;

  // power-on content of the nonvolatile cells
  initial begin
    for (i = 0; i < 16; i = i + 1) begin
      pot_preset_store[i] = `QPSC_PRESET_INIT;
    end
  end

  // ****************************************************************
  // nonvolatile write timer
  // ****************************************************************
  wire nv_busy; // internal write under way
  wire nv_done; // pulse in the cycle after the write ends
  reg nv_start; // one-cycle start pulse

  qpsc_nv_timer #(
    .CYCLES(NV_WRITE_CYCLES)
  ) u_nv_timer (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .start_i(nv_start),
    .busy_o(nv_busy),
    .done_o(nv_done)
  );

  // commit starts only on select rise after a staged write
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      nv_start <= 1'b0;
    end else begin
      // write protect is checked at commit time
      nv_start <= cs_rise && stage_valid && wp_n_s && !nv_busy;
    end
  end

  // cells change only at the end of the timed write
  always @(posedge CLK_I) begin
    if (nv_done) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (stage_all || stage_pot == i[1:0]) begin
          pot_preset_store[{i[1:0], stage_reg}] <= stage_val[i];
        end
      end
    end
  end

  // ****************************************************************
  // serial sequence engine
  // ****************************************************************
  reg [5:0] state; // frame state
  reg [2:0] bit_cnt; // bits of the current byte
  reg [7:0] shift_in; // receive shift register
  reg [7:0] shift_out; // transmit shift register
  reg [3:0] opcode; // operation of this frame
  reg [1:0] reg_sel; // reg_sel_hi, reg_sel_lo
  reg [1:0] pot_sel; // pot addressed
  wire [7:0] next_byte = {shift_in[6:0], si_s};
  wire byte_end = sck_rise && bit_cnt == 3'h7;
  wire [7:0] instr_wiper = wiper_position[next_byte[1:0]];
  wire [7:0] instr_preset = pot_preset_store[{next_byte[1:0], next_byte[3:2]}];
  wire [7:0] cur_wiper = wiper_position[pot_sel]; // wiper being stepped

  // receive, decode and move the wipers; one writer for all wipers
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      opcode <= 4'h0;
      reg_sel <= 2'h0;
      pot_sel <= 2'h0;
      stage_valid <= 1'b0;
      stage_all <= 1'b0;
      stage_pot <= 2'h0;
      stage_reg <= 2'h0;
      init_pend <= 1'b1;
      SPI_SO_O <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        wiper_position[i] <= `QPSC_WIPER_RST;
        stage_val[i] <= 8'h00;
      end
    end else if (init_pend) begin
      // recall preset zero once, after reset release
      init_pend <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        wiper_position[i] <= pot_preset_store[{i[1:0], 2'h0}];
      end
    end else if (cs_fall) begin
      // only a select fall opens a frame
      state <= ST_ID;
      bit_cnt <= 3'h0;
    end else if (cs_n_s) begin
      state <= ST_IDLE;
      stage_valid <= 1'b0; // commit start has seen it by now
    end else if (state == ST_STEP) begin
      // one step per clock pulse, held at both ends, never wraps
      if (sck_rise && si_s && cur_wiper != `QPSC_TAP_MAX) begin
        wiper_position[pot_sel] <= cur_wiper + 8'h01;
      end else if (sck_rise && !si_s && cur_wiper != `QPSC_TAP_MIN) begin
        wiper_position[pot_sel] <= cur_wiper - 8'h01;
      end
    end else if (sck_fall && state == ST_READ) begin
      SPI_SO_O <= shift_out[7];
      shift_out <= {shift_out[6:0], 1'b0};
    end else if (sck_rise && state != ST_IDLE && state != ST_READ) begin
      shift_in <= next_byte;
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_end) begin
        case (state)
          ST_ID: begin
            // middle bits are the host's to zero; not checked
            if (next_byte[`QPSC_ID_TYPE_MSB:`QPSC_ID_TYPE_LSB] == DEV_TYPE &&
                next_byte[`QPSC_ID_ADDR_MSB:`QPSC_ID_ADDR_LSB] ==
                strap_addr) begin
              state <= ST_INSTR;
            end else begin
              state <= ST_IDLE;
            end
          end
          ST_INSTR: begin
            opcode <= next_byte[`QPSC_OPC_MSB:`QPSC_OPC_LSB];
            reg_sel <= next_byte[`QPSC_REG_SEL_HI:`QPSC_REG_SEL_LO];
            pot_sel <= next_byte[`QPSC_POT_MSB:`QPSC_POT_LSB];
            state <= ST_IDLE;
            case (next_byte[`QPSC_OPC_MSB:`QPSC_OPC_LSB])
              `QPSC_OPC_RD_WIPER: begin
                shift_out <= instr_wiper;
                state <= ST_READ;
              end
              `QPSC_OPC_RD_PRESET: begin
                shift_out <= instr_preset;
                state <= ST_READ;
              end
              `QPSC_OPC_WR_WIPER, `QPSC_OPC_WR_PRESET: begin
                state <= ST_DATA;
              end
              `QPSC_OPC_PRESET_TO_WIPER: begin
                wiper_position[next_byte[1:0]] <= instr_preset;
              end
              `QPSC_OPC_ALL_PRESET_TO_WIPER: begin
                for (i = 0; i < 4; i = i + 1) begin
                  wiper_position[i] <=
                    pot_preset_store[{i[1:0], next_byte[3:2]}];
                end
              end
              `QPSC_OPC_WIPER_TO_PRESET,
              `QPSC_OPC_ALL_WIPER_TO_PRESET: begin
                // staging frozen while a write is pending
                if (!nv_busy) begin
                  stage_valid <= 1'b1;
                  stage_all <= next_byte[7:4] == `QPSC_OPC_ALL_WIPER_TO_PRESET;
                  stage_pot <= next_byte[1:0];
                  stage_reg <= next_byte[3:2];
                  for (i = 0; i < 4; i = i + 1) begin
                    stage_val[i] <= wiper_position[i];
                  end
                end
              end
              default: begin
                if (next_byte[7:4] == OPC_RD_STATUS) begin
                  shift_out <= {7'h00, nv_busy};
                  state <= ST_READ;
                end else if (next_byte[7:4] == OPC_STEP) begin
                  state <= ST_STEP;
                end
              end
            endcase
          end
          ST_DATA: begin
            state <= ST_IDLE;
            if (opcode == `QPSC_OPC_WR_WIPER) begin
              wiper_position[pot_sel] <= next_byte;
            end else if (!nv_busy) begin
              stage_valid <= 1'b1;
              stage_all <= 1'b0;
              stage_pot <= pot_sel;
              stage_reg <= reg_sel;
              stage_val[pot_sel] <= next_byte;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  // drive only read data while selected and not paused
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      SPI_SO_OE_O <= 1'b0;
      NV_WRITE_PENDING_O <= 1'b0;
    end else begin
      SPI_SO_OE_O <= state == ST_READ && !cs_n_s && !paused &&
                     !cs_fall;
      NV_WRITE_PENDING_O <= nv_busy;
    end
  end

  // a registered decode keeps exactly one tap on per array
  always @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      WIPER_TAP0_O <= `QPSC_TAP_RST;
      WIPER_TAP1_O <= `QPSC_TAP_RST;
      WIPER_TAP2_O <= `QPSC_TAP_RST;
      WIPER_TAP3_O <= `QPSC_TAP_RST;
    end else begin
      WIPER_TAP0_O <= tap_onehot(wiper_position[0]);
      WIPER_TAP1_O <= tap_onehot(wiper_position[1]);
      WIPER_TAP2_O <= tap_onehot(wiper_position[2]);
      WIPER_TAP3_O <= tap_onehot(wiper_position[3]);
    end
  end

endmodule // qpsc_serial_ctrl

`default_nettype wire

// ### test/qpsc_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// protocol checker on the top ports
// ****
module qpsc_checker #(
  parameter int NV_WRITE_CYCLES = 250000
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic SPI_SCK_I,
  input wire logic SPI_CS_N_I,
  input wire logic SPI_HOLD_N_I,
  input wire logic SPI_SO_O,
  input wire logic SPI_SO_OE_O,
  input wire logic WP_N_I,
  input wire logic NV_WRITE_PENDING_O,
  input wire logic [255:0] WIPER_TAP0_O,
  input wire logic [255:0] WIPER_TAP1_O,
  input wire logic [255:0] WIPER_TAP2_O,
  input wire logic [255:0] WIPER_TAP3_O
);
  logic [17:0] nv_cnt; // cycles spent pending
  logic [3:0] idle_cnt; // deselected cycles, saturating
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // helper counters; idle count skips the power-up load
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      nv_cnt <= '0;
      idle_cnt <= '0;
    end else begin
      nv_cnt <= NV_WRITE_PENDING_O ? nv_cnt + 18'h1 : 18'h0;
      idle_cnt <= !SPI_CS_N_I ? 4'h0 :
                  (&idle_cnt ? idle_cnt : idle_cnt + 4'h1);
    end
  end
  so_float_desel_a: assert property (
    SPI_CS_N_I [*6] |-> !SPI_SO_OE_O) else $error("output on while idle");
  hold_float_a: assert property (
    !SPI_HOLD_N_I [*6] |-> !SPI_SO_OE_O) else $error("output on in pause");
  oe_start_a: assert property (
    $rose(SPI_SO_OE_O) |-> !SPI_CS_N_I && SPI_HOLD_N_I && !SPI_SCK_I)
    else $error("output enabled outside a read");
  so_on_fall_a: assert property (
    SPI_SO_OE_O && $past(SPI_SO_OE_O) && $changed(SPI_SO_O) |-> !SPI_SCK_I)
    else $error("read data moved while clock high");
  taps_one_hot_a: assert property (
    $onehot(WIPER_TAP0_O) && $onehot(WIPER_TAP1_O) &&
    $onehot(WIPER_TAP2_O) && $onehot(WIPER_TAP3_O))
    else $error("tap not one-hot");
  nv_len_a: assert property (
    $fell(NV_WRITE_PENDING_O) |-> nv_cnt == NV_WRITE_CYCLES)
    else $error("commit length wrong");
  nv_bound_a: assert property (
    nv_cnt <= NV_WRITE_CYCLES) else $error("commit too long");
  nv_after_cs_a: assert property (
    $rose(NV_WRITE_PENDING_O) |-> SPI_CS_N_I && $past(SPI_CS_N_I, 2))
    else $error("commit began while selected");
  nv_wp_gate_a: assert property (
    $rose(NV_WRITE_PENDING_O) |-> WP_N_I) else $error("commit while protected");
  taps_idle_a: assert property (
    idle_cnt == 4'hF |-> $stable({WIPER_TAP0_O, WIPER_TAP1_O,
    WIPER_TAP2_O, WIPER_TAP3_O})) else $error("tap moved while idle");
  commit_c: cover property ($fell(NV_WRITE_PENDING_O));
  read_c: cover property ($rose(SPI_SO_OE_O));
  pause_c: cover property ($fell(SPI_HOLD_N_I) && !SPI_CS_N_I);
endmodule // qpsc_checker

bind qpsc_serial_ctrl qpsc_checker #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_chk (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .SPI_SCK_I(SPI_SCK_I),
  .SPI_CS_N_I(SPI_CS_N_I), .SPI_HOLD_N_I(SPI_HOLD_N_I), .SPI_SO_O(SPI_SO_O),
  .SPI_SO_OE_O(SPI_SO_OE_O), .WP_N_I(WP_N_I),
  .NV_WRITE_PENDING_O(NV_WRITE_PENDING_O), .WIPER_TAP0_O(WIPER_TAP0_O),
  .WIPER_TAP1_O(WIPER_TAP1_O), .WIPER_TAP2_O(WIPER_TAP2_O),
  .WIPER_TAP3_O(WIPER_TAP3_O));
`default_nettype wire

// ### test/qpsc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// host serial master, mode 0, 320 ns clock
// ****
module qpsc_host_model (
  input wire logic clk_i,
  input wire logic so_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  output logic hold_n_o
);
  // idle: clock parked low, deselected
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    hold_n_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // id, instruction, nt tail bits; last 16 bits seen on so come back
  task automatic frame(input logic [7:0] id, input logic [7:0] ins,
      input logic [15:0] tail, input int nt, input int pause_at,
      output logic [15:0] rd);
    logic [31:0] bits;
    bits = {id, ins, tail << (16 - nt)};
    rd = '0;
    cs_n_o <= 1'b0;
    tick(8);
    for (int i = 0; i < 16 + nt; i++) begin
      si_o <= bits[31 - i];
      if (i == pause_at) begin
        tick(1);
        hold_n_o <= 1'b0;
        tick(4);
        sck_o <= 1'b1; // a clock pulse inside the pause must be ignored
        tick(3);
        sck_o <= 1'b0;
        tick(5);
        hold_n_o <= 1'b1;
      end
      // 5 low, 3 high keeps si steady around the rise
      tick(5);
      rd = {rd[14:0], so_i};
      sck_o <= 1'b1;
      tick(3);
      sck_o <= 1'b0;
    end
    tick(5);
    cs_n_o <= 1'b1;
    si_o <= ~si_o; // stale level must not be trusted
    tick(8);
  endtask
endmodule // qpsc_host_model
`default_nettype wire

// ### test/quad_pot_serial_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module quad_pot_serial_control_tb_top;
  localparam logic [3:0] DEV = 4'hA; // arbitrary type code
  localparam logic [3:0] STEP = 4'h2;
  localparam logic [1:0] STRAP = 2'h2;
  localparam logic [7:0] ID = {DEV, 2'h0, STRAP};
  localparam int NVC = 600; // short commit keeps the run brief
  logic clk, sys_rst, wp_n, sck, cs_n, si, hold_n, so, so_oe, pend;
  logic [1:0] strap;
  logic [255:0] tap0, tap1, tap2, tap3;
  logic [15:0] r;
  int bad_count = 0;
  int num_checks = 0;
  wire logic so_line; // floats when not driven
  assign so_line = so_oe ? so : 1'bz;
  always #20 clk = ~clk;
  qpsc_serial_ctrl #(.DEV_TYPE(DEV), .OPC_RD_STATUS(4'h5), .OPC_STEP(STEP),
    .NV_WRITE_CYCLES(18'(NVC))) DUT (
    .CLK_I(clk), .SYS_RST_I(sys_rst), .SPI_SCK_I(sck), .SPI_CS_N_I(cs_n),
    .SPI_SI_I(si), .SPI_HOLD_N_I(hold_n), .SPI_SO_O(so), .SPI_SO_OE_O(so_oe),
    .WP_N_I(wp_n), .STRAP_ADDR_I(strap), .NV_WRITE_PENDING_O(pend),
    .WIPER_TAP0_O(tap0), .WIPER_TAP1_O(tap1), .WIPER_TAP2_O(tap2),
    .WIPER_TAP3_O(tap3));
  qpsc_host_model host (.clk_i(clk), .so_i(so_line), .sck_o(sck),
    .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n));
  // ****
  // compare and wait helpers
  // ****
  task automatic final_report;
    if (bad_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t byte %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_tap(input int p, input logic [7:0] v);
    logic [255:0] t;
    t = p == 0 ? tap0 : p == 1 ? tap1 : p == 2 ? tap2 : tap3;
    num_checks++;
    if (t !== (256'h1 << v)) begin
      bad_count++;
      $display("FAIL %0t tap of pot %0d, want %h", $time, p, v);
    end
  endtask
  task automatic wr(input logic [7:0] id, input logic [7:0] ins,
      input logic [7:0] d);
    host.frame(id, ins, {8'h00, d}, 8, -1, r);
  endtask
  task automatic rd(input logic [7:0] ins, output logic [7:0] v);
    host.frame(ID, ins, 16'h0000, 8, -1, r);
    v = r[7:0];
  endtask
  // bounded wait on the commit flag
  task automatic wait_pend(input logic lvl);
    for (int i = 0; i < 2000 && pend !== lvl; i++)
      @(posedge clk);
    if (pend !== lvl) begin
      bad_count++;
      $display("FAIL %0t pending flag wait ran out", $time);
      final_report();
    end
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_power_up;
    repeat (4) @(posedge clk);
    for (int p = 0; p < 4; p++)
      chk_tap(p, 8'h80);
    chk_byte({7'h00, so_oe}, 8'h00);
  endtask
  task automatic t_wiper;
    logic [7:0] v, g;
    for (int p = 0; p < 4; p++) begin
      v = 8'(8'h21 * (p + 1));
      wr(ID, {4'hA, 2'h0, 2'(p)}, v);
      chk_tap(p, v);
      rd({4'h9, 2'h0, 2'(p)}, g);
      chk_byte(g, v);
    end
  endtask
  // wrong type or strap leaves the frame unanswered
  task automatic t_bad_id;
    wr({4'h3, 2'h0, STRAP}, {4'hA, 4'h0}, 8'hEE);
    chk_tap(0, 8'h21);
    wr({DEV, 2'h0, ~STRAP}, {4'hA, 4'h0}, 8'hEE);
    chk_tap(0, 8'h21);
    host.frame({DEV, 2'h0, ~STRAP}, {4'h9, 4'h0}, 16'h0000, 8, -1, r);
    chk_byte(r[7:0], 8'hZZ);
  endtask
  task automatic t_nv;
    logic [7:0] g;
    wr(ID, {4'hC, 2'h2, 2'h1}, 8'h5A);
    wait_pend(1'b1);
    rd({4'h5, 4'h0}, g);
    chk_byte(g, 8'h01);
    wr(ID, {4'hC, 2'h2, 2'h1}, 8'h33);
    wait_pend(1'b0);
    rd({4'hB, 2'h2, 2'h1}, g);
    chk_byte(g, 8'h5A);
    rd({4'h5, 4'h0}, g);
    chk_byte(g, 8'h00);
    host.frame(ID, {4'hD, 2'h2, 2'h1}, 16'h0000, 0, -1, r);
    chk_tap(1, 8'h5A);
  endtask
  task automatic t_wp;
    logic [7:0] g;
    wp_n <= 1'b0;
    wr(ID, {4'hC, 2'h0, 2'h2}, 8'h3C);
    chk_byte({7'h00, pend}, 8'h00);
    wp_n <= 1'b1;
    rd({4'hB, 2'h0, 2'h2}, g);
    chk_byte(g, 8'h80);
  endtask
  // stepping stops at both ends
  task automatic t_step;
    wr(ID, {4'hA, 2'h0, 2'h3}, 8'hFE);
    host.frame(ID, {STEP, 2'h0, 2'h3}, 16'h0007, 3, -1, r);
    chk_tap(3, 8'hFF);
    wr(ID, {4'hA, 2'h0, 2'h3}, 8'h01);
    host.frame(ID, {STEP, 2'h0, 2'h3}, 16'h0000, 3, -1, r);
    chk_tap(3, 8'h00);
  endtask
  // pauses with a stray clock pulse keep write and read in step
  task automatic t_pause;
    host.frame(ID, {4'hA, 4'h0}, 16'h00C3, 8, 20, r);
    chk_tap(0, 8'hC3);
    host.frame(ID, {4'h9, 4'h0}, 16'h0000, 8, 19, r);
    chk_byte(r[7:0], 8'hC3);
  endtask
  // wiper to preset for one pot and for all, then all back
  task automatic t_xfr;
    logic [7:0] g;
    host.frame(ID, {4'hE, 2'h3, 2'h2}, 16'h0000, 0, -1, r);
    wait_pend(1'b1);
    wait_pend(1'b0);
    rd({4'hB, 2'h3, 2'h2}, g);
    chk_byte(g, 8'h63);
    host.frame(ID, {4'h8, 2'h1, 2'h0}, 16'h0000, 0, -1, r);
    wait_pend(1'b1);
    wait_pend(1'b0);
    wr(ID, {4'hA, 2'h0, 2'h0}, 8'h11);
    host.frame(ID, {4'h1, 2'h1, 2'h0}, 16'h0000, 0, -1, r);
    chk_tap(0, 8'hC3);
    rd({4'hB, 2'h1, 2'h1}, g);
    chk_byte(g, 8'h5A);
  endtask
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    wp_n = 1'b1;
    strap = STRAP;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_power_up();
    t_wiper();
    t_bad_id();
    t_nv();
    t_wp();
    t_step();
    t_pause();
    t_xfr();
    final_report();
  end
endmodule // quad_pot_serial_control_tb_top
`default_nettype wire
